// >>> rtl/scsl_pkg.sv
// Constants shared by the chained switch loader and its FIFO.
// Assumes a 100 MHz system clock and an 8-bit switch word.
package scsl_pkg;
  localparam int unsigned SW_W          = 8;
  localparam int unsigned LOAD_MIN_BITS = 8;
  localparam int unsigned CNT_W         = 4;
  localparam int unsigned FIFO_DEPTH    = 8;
  localparam int unsigned FIFO_AW       = 3;
  localparam int unsigned SYNC_N        = 4;
  localparam int unsigned SY_CS         = 0;
  localparam int unsigned SY_TOG        = 1;
  localparam int unsigned SY_SD         = 2;
  localparam int unsigned SY_SEL        = 3;
  localparam logic [7:0]  SW_RESET      = 8'h00;
  localparam logic [3:0]  CNT_RESET     = 4'h0;
  localparam logic [3:0]  CNT_LOAD_MIN  = 4'h8;
  typedef logic [SW_W-1:0] scsl_word_t;
endpackage : scsl_pkg

// >>> rtl/scsl_fifo_if.sv
// Handshake bundle between the loader and its word FIFO.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
interface scsl_fifo_if;
  import scsl_pkg::*;
  logic       wr_valid;
  logic       wr_ready;
  scsl_word_t wr_data;
  logic       rd_valid;
  logic       rd_ready;
  scsl_word_t rd_data;
  modport src  (output wr_valid, output wr_data, input wr_ready,
                input rd_valid, input rd_data, output rd_ready);
  modport fifo (input wr_valid, input wr_data, output wr_ready,
                output rd_valid, output rd_data, input rd_ready);
endinterface : scsl_fifo_if

// >>> rtl/scsl_fifo.sv
// Flip-flop FIFO of switch words, valid/ready on both sides.
// Assumes a single clock and a synchronous clear.
`timescale 1ns/1ps
module scsl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW    = 3
) (
  // Clock and reset
  input wire logic  sys_clk,
  input wire logic  sys_rst,
  input wire logic  clr,
  // Word ports
  scsl_fifo_if.fifo fq
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign fq.wr_ready = (cnt_r != DEPTH[AW:0]);
  assign fq.rd_valid = (cnt_r != '0);
  assign fq.rd_data  = mem_r[rp_r];
  assign push        = fq.wr_valid & fq.wr_ready;
  assign pop         = fq.rd_valid & fq.rd_ready;

  always_comb
  begin
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    for (int i = 0; i < DEPTH; i++)
    begin
      mem_nxt[i] = mem_r[i];
    end
    if (clr)
    begin
      wp_nxt  = '0;
      rp_nxt  = '0;
      cnt_nxt = '0;
    end
    else
    begin
      if (push)
      begin
        mem_nxt[wp_r] = fq.wr_data;
        wp_nxt        = wp_r + 1'b1;
      end
      if (pop)
      begin
        rp_nxt = rp_r + 1'b1;
      end
      cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_r[i] <= '0;
      end
    end
    else
    begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      mem_r <= mem_nxt;
    end
  end
endmodule : scsl_fifo

// >>> rtl/scsl_loader.sv
// Serial chain switch loader: shift register on the serial clock,
// load decision and switch register on sys_clk.
// Assumes cs_n and din are launched by the controller relative to sclk.
`timescale 1ns/1ps
module scsl_loader (
  // System clock and reset
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  // Device pins
  input  wire logic                shutdown_n,
  input  wire logic                spi_sel,
  // Serial link
  input  wire logic                sclk,
  input  wire logic                cs_n,
  input  wire logic                din,
  output logic                     dout,
  // Switch controls
  output scsl_pkg::scsl_word_t     sw_ctl,
  output logic                     switch_eight_ctl,
  output logic                     switch_one_ctl
);
  import scsl_pkg::*;

  // Link domain: reset and mode levels brought onto sclk
  logic       rst_l1_r, rst_l2_r, sd_l1_r, sd_l2_r, sel_l1_r, sel_l2_r;
  logic       link_clr;
  scsl_word_t shift_r, shift_nxt;
  logic       tog_r, tog_nxt;

  always_ff @(posedge sclk)
  begin
    rst_l1_r <= sys_rst;
    rst_l2_r <= rst_l1_r;
    sd_l1_r  <= shutdown_n;
    sd_l2_r  <= sd_l1_r;
    sel_l1_r <= spi_sel;
    sel_l2_r <= sel_l1_r;
  end

  // Shutdown or two-wire mode holds the shift path cleared
  assign link_clr = rst_l2_r | ~sd_l2_r | ~sel_l2_r;

  always_comb
  begin
    shift_nxt = shift_r;
    tog_nxt   = tog_r;
    if (link_clr)
    begin
      shift_nxt = SW_RESET;
      tog_nxt   = 1'b0;
    end
    else if (!cs_n)
    begin
      shift_nxt = {shift_r[SW_W-2:0], din};
      tog_nxt   = ~tog_r;
    end
  end

  always_ff @(posedge sclk)
  begin
    shift_r <= shift_nxt;
    tog_r   <= tog_nxt;
  end

  // Old contents leave first, then the incoming bits
  assign dout = shift_r[SW_W-1];

  // System domain synchronisers, one per crossing level
  logic [SYNC_N-1:0] sy1_r, sy2_r, sy_in;
  assign sy_in = {spi_sel, shutdown_n, tog_r, cs_n};

  genvar g;
  generate
    for (g = 0; g < SYNC_N; g++)
    begin : g_sync
      always_ff @(posedge sys_clk)
      begin
        sy1_r[g] <= sy_in[g];
        sy2_r[g] <= sy1_r[g];
      end
    end
  endgenerate

  // Loader state
  logic                 cs_d_r, cs_d_nxt, tog_d_r, tog_d_nxt;
  logic [CNT_W-1:0]     cnt_r, cnt_nxt;
  scsl_word_t           word_r, word_nxt;
  logic                 pend_r, pend_nxt;
  scsl_word_t           pdat_r, pdat_nxt;
  scsl_word_t           sw_r, sw_nxt;
  logic                 bit_ev, cs_rise, cs_fall, sys_clr;
  logic [CNT_W-1:0]     cnt_now;
  scsl_word_t           word_now;

  scsl_fifo_if fq ();

  assign sys_clr = sys_rst | ~sy2_r[SY_SD];
  assign bit_ev  = sy2_r[SY_TOG] ^ tog_d_r;
  assign cs_rise = sy2_r[SY_CS] & ~cs_d_r;
  assign cs_fall = ~sy2_r[SY_CS] & cs_d_r;

  // Shift word is stable for a whole sclk period after the toggle
  assign word_now = bit_ev ? shift_r : word_r;
  assign cnt_now  = (bit_ev && cnt_r != CNT_LOAD_MIN) ? cnt_r + 1'b1 : cnt_r;

  assign fq.wr_valid = pend_r;
  assign fq.wr_data  = pdat_r;
  // Drain only while the link is idle, so a full FIFO stalls the load
  assign fq.rd_ready = sy2_r[SY_CS] & ~sys_clr;

  always_comb
  begin
    cs_d_nxt  = sy2_r[SY_CS];
    tog_d_nxt = sy2_r[SY_TOG];
    word_nxt  = word_now;
    cnt_nxt   = cnt_now;
    pend_nxt  = pend_r;
    pdat_nxt  = pdat_r;
    sw_nxt    = sw_r;
    if (pend_r && fq.wr_ready)
    begin
      pend_nxt = 1'b0;
    end
    if (cs_fall)
    begin
      cnt_nxt = CNT_RESET;
    end
    // Too few clocks: nothing is queued, switches keep their state
    if (cs_rise && sy2_r[SY_SEL] && cnt_now >= CNT_LOAD_MIN)
    begin
      pend_nxt = 1'b1;
      pdat_nxt = word_now;
      cnt_nxt  = CNT_RESET;
    end
    if (fq.rd_valid && fq.rd_ready)
    begin
      sw_nxt = fq.rd_data;
    end
    if (sys_clr)
    begin
      word_nxt = SW_RESET;
      cnt_nxt  = CNT_RESET;
      pend_nxt = 1'b0;
      pdat_nxt = SW_RESET;
      sw_nxt   = SW_RESET;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cs_d_r  <= 1'b1;
      tog_d_r <= 1'b0;
      word_r  <= SW_RESET;
      cnt_r   <= CNT_RESET;
      pend_r  <= 1'b0;
      pdat_r  <= SW_RESET;
      sw_r    <= SW_RESET;
    end
    else
    begin
      cs_d_r  <= cs_d_nxt;
      tog_d_r <= tog_d_nxt;
      word_r  <= word_nxt;
      cnt_r   <= cnt_nxt;
      pend_r  <= pend_nxt;
      pdat_r  <= pdat_nxt;
      sw_r    <= sw_nxt;
    end
  end

  scsl_fifo #(
    .WIDTH (SW_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .clr     (sys_clr),
    .fq      (fq)
  );

  // Whole word applied at once
  assign sw_ctl           = sw_r;
  assign switch_eight_ctl = sw_r[SW_W-1];
  assign switch_one_ctl   = sw_r[0];
endmodule : scsl_loader

// >>> bench/scsl_loader_asserts.sv
// Port checker for the chained switch loader.
// Assumes sclk may idle-run between frames with cs_n high.
`timescale 1ns/1ps
module scsl_loader_asserts (
  // Clock and pins
  input wire logic                 sys_clk,
  input wire logic                 sys_rst,
  input wire logic                 shutdown_n,
  input wire logic                 spi_sel,
  // Link and switches
  input wire logic                 sclk,
  input wire logic                 cs_n,
  input wire logic                 din,
  input wire logic                 dout,
  input wire scsl_pkg::scsl_word_t sw_ctl,
  input wire logic                 switch_eight_ctl,
  input wire logic                 switch_one_ctl
);
  import scsl_pkg::*;
  a_mirror_ends: assert property (@(posedge sys_clk) disable iff (sys_rst)
    {switch_eight_ctl, switch_one_ctl} == {sw_ctl[7], sw_ctl[0]}) else $error("end bits");
  a_rst_opens: assert property (@(posedge sys_clk) sys_rst |=> sw_ctl == 8'h00)
    else $error("reset left switches");
  a_shdn_opens: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !shutdown_n [*4] |-> sw_ctl == 8'h00) else $error("shutdown left switches");
  // Eight cycles covers the longest load lag after a select rise
  a_frame_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!cs_n && shutdown_n) [*8] |=> $stable(sw_ctl)) else $error("change mid frame");
  a_sel_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!spi_sel && shutdown_n) [*8] |=> $stable(sw_ctl)) else $error("change in other mode");
  a_dout_shift: assert property (@(posedge sclk) disable iff (sys_rst)
    (!cs_n && spi_sel && shutdown_n) [*8] |=> dout == $past(din, 8)) else $error("dout");
  a_sel_dout: assert property (@(posedge sclk) disable iff (sys_rst)
    !spi_sel [*4] |-> dout == 1'b0) else $error("dout in other mode");
  a_shdn_dout: assert property (@(posedge sclk) disable iff (sys_rst)
    !shutdown_n [*4] |-> dout == 1'b0) else $error("dout in shutdown");
endmodule : scsl_loader_asserts
bind scsl_loader scsl_loader_asserts u_chk (.sys_clk, .sys_rst, .shutdown_n, .spi_sel,
  .sclk, .cs_n, .din, .dout, .sw_ctl, .switch_eight_ctl, .switch_one_ctl);

// >>> bench/scsl_ctl_model.sv
// Serial controller model on the loader's link pins.
// Assumes one task call at a time.
`timescale 1ns/1ps
module scsl_ctl_model (
  // Link
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  int half = 40;
  initial
  begin
    sclk = 0;
    cs_n = 1;
    din = 0;
  end
  // Select high: only lets the link reset and mode syncs settle
  task idle(input int n);
    repeat (n)
    begin
      #half sclk = 1;
      #half sclk = 0;
    end
  endtask : idle
  task send(input logic [15:0] bits, input int n, output logic [15:0] cap);
    cap = 16'h0000;
    cs_n = 0;
    for (int i = n - 1; i >= 0; i--)
    begin
      din = bits[i];
      #half;
      // Sample before the rise: dout moves right after it
      cap = {cap[14:0], dout};
      sclk = 1;
      #half sclk = 0;
    end
    cs_n = 1;
    din = ~din; // Released line must not look held
    #(4 * half);
  endtask : send
endmodule : scsl_ctl_model

// >>> bench/scsl_loader_tb.sv
// Self-checking bench for the chained switch loader.
// Assumes the controller model scsl_ctl_model.
`timescale 1ns/1ps
module scsl_loader_tb;
  import scsl_pkg::*;
  logic        sys_clk = 0, sys_rst = 1, shutdown_n = 1, spi_sel = 1;
  wire         sclk, cs_n, din, dout, eight_ctl, one_ctl;
  scsl_word_t  sw_ctl;
  scsl_word_t  sw2_ctl;
  logic [15:0] got;
  int          bad_count = 0, tests_run = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  scsl_ctl_model u_ctl (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
  scsl_loader u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .shutdown_n(shutdown_n),
    .spi_sel(spi_sel), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .sw_ctl(sw_ctl),
    .switch_eight_ctl(eight_ctl), .switch_one_ctl(one_ctl));
  // Second loader chained behind the first, sharing select and clock
  scsl_loader u_dut2 (.sys_clk(sys_clk), .sys_rst(sys_rst), .shutdown_n(shutdown_n),
    .spi_sel(spi_sel), .sclk(sclk), .cs_n(cs_n), .din(dout), .dout(), .sw_ctl(sw2_ctl),
    .switch_eight_ctl(), .switch_one_ctl());
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task settle;
    repeat (12) @(posedge sys_clk);
    #1;
  endtask : settle
  task t_load;
    u_ctl.half = 70; // Slow controller
    u_ctl.send(16'h00A5, 8, got);
    u_ctl.half = 40;
    settle();
    chk(sw_ctl, 8'hA5);
    chk({eight_ctl, one_ctl}, 2'b11);
    $display("load test done");
  endtask : t_load
  // Short frame leaves switches; chain frame shows old shift first
  task t_chain;
    u_ctl.send(16'h000A, 5, got);
    settle();
    chk(got[4:0], 5'h14);
    chk(sw_ctl, 8'hA5);
    u_ctl.send(16'h3C01, 16, got);
    settle();
    chk(got, 16'hAA3C);
    chk({sw_ctl, eight_ctl, one_ctl}, 10'h005);
    chk(sw2_ctl, 8'h3C);
    $display("chain test done");
  endtask : t_chain
  task t_modes;
    spi_sel = 0;
    u_ctl.send(16'h00FF, 8, got);
    settle();
    chk(sw_ctl, 8'h01);
    spi_sel = 1;
    shutdown_n = 0;
    u_ctl.idle(4);
    u_ctl.send(16'h00FF, 8, got);
    settle();
    chk(sw_ctl, 8'h00);
    shutdown_n = 1;
    u_ctl.idle(4);
    u_ctl.send(16'h005A, 8, got);
    settle();
    chk({got[7:0], sw_ctl}, 16'h005A);
    $display("mode test done");
  endtask : t_modes
  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      end_sim();
    end
  end
  initial
  begin
    u_ctl.idle(4); // Link domain needs sclk edges to see reset
    repeat (6) @(posedge sys_clk);
    #1 sys_rst = 0;
    u_ctl.idle(4);
    t_load();
    t_chain();
    t_modes();
    end_sim();
  end
endmodule : scsl_loader_tb
